// ### verilog/dhl_pkg.sv
// Purpose: constants, types and lane maps for the display host bus controller
// Assumes: mclk at 100 MHz; one display module on the far side
// Notes:   straps, lane maps and RGB geometry shared by design and bench
package dhl_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS    = 10;
    localparam int T_RESW_NS = 10000;
    localparam int T_REST_NS = 120000000;
    localparam int T_CS_NS   = 15;
    localparam int T_WRL_NS  = 15;
    localparam int T_WC_NS   = 66;
    localparam int T_RDL_NS  = 355;
    localparam int T_RDH_NS  = 90;
    localparam int T_DOT_NS  = 100;
    localparam int RESW_CYC  = (T_RESW_NS + CLK_NS - 1) / CLK_NS;
    localparam int REST_CYC  = (T_REST_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_CYC    = (T_CS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRL_CYC   = (T_WRL_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRH_CYC   = (T_WC_NS + CLK_NS - 1) / CLK_NS - WRL_CYC;
    localparam int RDL_CYC   = (T_RDL_NS + CLK_NS - 1) / CLK_NS;
    localparam int RDH_CYC   = (T_RDH_NS + CLK_NS - 1) / CLK_NS;
    localparam int DOT_HALF  = (T_DOT_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    // ------------------------------------------------------------
    // RGB geometry
    // ------------------------------------------------------------
    localparam int H_ACTIVE = 240;
    localparam int V_ACTIVE = 320;
    localparam int H_SYNC   = 10;
    localparam int H_BACK   = 20;
    localparam int H_FRONT  = 10;
    localparam int V_SYNC   = 2;
    localparam int V_BACK   = 2;
    localparam int V_FRONT  = 4;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_PAR8, MODE_PAR9, MODE_PAR16, MODE_PAR18,
        MODE_RGB6, MODE_RGB16, MODE_RGB18, MODE_SPI4
    } dhl_mode_t;
    typedef enum logic {PARALLEL_LAYOUT_LOW, PARALLEL_LAYOUT_HIGH} dhl_layout_t;
    typedef struct packed {
        logic        read;
        logic        is_data;
        logic [17:0] word;
    } dhl_req_t;
    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } dhl_pix_t;
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [3:0] strap_code(dhl_mode_t m, dhl_layout_t l);
        strap_code = {l, m};
    endfunction
    // Word to lanes; lanes outside the mode come out low
    function automatic logic [17:0] lane_map(dhl_mode_t m, dhl_layout_t l,
                                             logic [17:0] w);
        logic hi;
        hi = (l == PARALLEL_LAYOUT_HIGH);
        case (m)
            MODE_PAR8:  lane_map = hi ? {w[7:0], 10'h000} : {10'h000, w[7:0]};
            MODE_PAR9:  lane_map = hi ? {w[8:0], 9'h000} : {9'h000, w[8:0]};
            MODE_PAR16: lane_map = {w[15:8], 1'b0, w[7:0], 1'b0};
            MODE_PAR18: lane_map = w;
            MODE_RGB6:  lane_map = {12'h000, w[5:0]};
            MODE_RGB16: lane_map = {w[17:13], 1'b0, w[11:6], w[5:1], 1'b0};
            MODE_RGB18: lane_map = w;
            default:    lane_map = 18'h0_0000;
        endcase
    endfunction
    function automatic logic [17:0] lane_unmap(dhl_mode_t m, dhl_layout_t l,
                                               logic [17:0] d);
        logic hi;
        hi = (l == PARALLEL_LAYOUT_HIGH);
        case (m)
            MODE_PAR8:  lane_unmap = {10'h000, hi ? d[17:10] : d[7:0]};
            MODE_PAR9:  lane_unmap = {9'h000, hi ? d[17:9] : d[8:0]};
            MODE_PAR16: lane_unmap = {2'b00, d[17:10], d[8:1]};
            MODE_PAR18: lane_unmap = d;
            default:    lane_unmap = 18'h0_0000;
        endcase
    endfunction
endpackage

// ### verilog/dhl_host.sv
// Purpose: host side of a TFT display module bus: reset, straps,
//          8080-style transfers and RGB pixel streaming
// Assumes: mode and layout settle while rstn is low or the display
//          reset pulse is running; lanes in pass two flip-flops
// Notes:   pixel clock is divided from mclk, so one clock domain
`timescale 1ns/1ps
module dhl_host #(
    parameter int REST_CYCLES = dhl_pkg::REST_CYC,
    parameter int H_ACT       = dhl_pkg::H_ACTIVE,
    parameter int V_ACT       = dhl_pkg::V_ACTIVE
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // Configuration
    input  wire dhl_pkg::dhl_mode_t   cfg_mode,
    input  wire dhl_pkg::dhl_layout_t cfg_layout,
    output logic                     link_ready,
    // Bus transfers
    input  wire logic                req_valid,
    input  wire dhl_pkg::dhl_req_t    req,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [17:0]              rsp_word,
    // Pixel stream
    input  wire logic                pix_valid,
    input  wire dhl_pkg::dhl_pix_t    pix,
    output logic                     pix_ready,
    // Display pins
    output logic                     module_reset_n,
    output logic                     iface_strap_0,
    output logic                     iface_strap_1,
    output logic                     iface_strap_2,
    output logic                     iface_strap_3,
    output logic                     chip_select_n,
    output logic                     cmd_data_select,
    output logic                     write_strobe_n,
    output logic                     read_strobe_n,
    output logic                     frame_sync_n,
    output logic                     line_sync_n,
    output logic                     pixel_clock,
    output logic                     data_enable,
    output logic [17:0]              host_lanes_out,
    output logic                     host_lanes_oe,
    input  wire logic [17:0]         host_lanes_in
);
    import dhl_pkg::*;

    localparam int DOT_PER = 2 * DOT_HALF;
    localparam logic [10:0] H_A0   = 11'(H_SYNC + H_BACK);
    localparam logic [10:0] V_A0   = 11'(V_SYNC + V_BACK);
    localparam logic [10:0] V_LAST = 11'(V_SYNC + V_BACK + V_ACT + V_FRONT - 1);

    typedef enum logic [1:0] {RS_HOLD, RS_WAIT, RS_RUN} dhl_rst_t;
    typedef enum logic [1:0] {BS_IDLE, BS_SETUP, BS_STROBE, BS_RECOVER} dhl_bus_t;

    dhl_rst_t    rst_st;
    logic [31:0] rst_cnt;
    dhl_mode_t   mode;
    dhl_layout_t layout;
    dhl_bus_t    bus_st;
    logic [5:0]  bus_cnt;
    dhl_req_t    cur;
    logic [17:0] lanes_meta;
    logic [17:0] lanes_sync;
    logic        running;
    logic        is_par;
    logic        is_rgb;
    logic        take;
    logic [3:0]  div_cnt;
    logic        dot_fall;
    logic        dot_pre;
    logic [10:0] h_cnt;
    logic [10:0] v_cnt;
    logic [10:0] next_h;
    logic [10:0] next_v;
    logic [10:0] act_clks;
    logic [10:0] h_last;
    logic        next_act;
    logic [1:0]  ph;
    dhl_pix_t    held;
    logic        held_ok;
    logic [17:0] rgb_word;

    assign running  = (rst_st == RS_RUN);
    assign is_par   = (mode <= MODE_PAR18);
    assign is_rgb   = (mode == MODE_RGB6) || (mode == MODE_RGB16) || (mode == MODE_RGB18);
    assign take     = pix_ready && pix_valid;
    assign dot_fall = pixel_clock && (div_cnt == 4'(DOT_HALF - 1));
    assign dot_pre  = pixel_clock && (div_cnt == 4'(DOT_HALF - 2));
    // Three lane clocks per pixel in 6-bit mode
    assign act_clks = (mode == MODE_RGB6) ? 11'(3 * H_ACT) : 11'(H_ACT);
    assign h_last   = H_A0 + act_clks + 11'(H_FRONT) - 11'd1;

    // ------------------------------------------------------------
    // Reset pulse and mode capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rst_st         <= RS_HOLD;
            rst_cnt        <= '0;
            module_reset_n <= 1'b0;
            link_ready     <= 1'b0;
        end else begin
            rst_cnt <= rst_cnt + 32'd1;
            case (rst_st)
                RS_HOLD: begin
                    if (rst_cnt == 32'(RESW_CYC - 1)) begin
                        rst_cnt        <= '0;
                        module_reset_n <= 1'b1;
                        rst_st         <= RS_WAIT;
                    end
                end
                RS_WAIT: begin
                    if (rst_cnt == 32'(REST_CYCLES - 1)) begin
                        link_ready <= 1'b1;
                        rst_st     <= RS_RUN;
                    end
                end
                RS_RUN: rst_cnt <= '0;
                default: rst_st <= RS_HOLD;
            endcase
        end
    end

    // Straps follow the mode only while the display sits in reset
    always_ff @(posedge mclk) begin
        if (!rstn || rst_st == RS_HOLD) begin
            mode   <= cfg_mode;
            layout <= cfg_layout;
        end
    end

    always_ff @(posedge mclk) begin
        {iface_strap_3, iface_strap_2, iface_strap_1, iface_strap_0}
            <= strap_code(mode, layout);
    end

    always_ff @(posedge mclk) begin
        lanes_meta <= host_lanes_in;
        lanes_sync <= lanes_meta;
    end

    // ------------------------------------------------------------
    // Parallel transfer engine
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bus_st          <= BS_IDLE;
            bus_cnt         <= '0;
            cur             <= '0;
            req_ready       <= 1'b0;
            chip_select_n   <= 1'b1;
            cmd_data_select <= 1'b1;
            write_strobe_n  <= 1'b1;
            read_strobe_n   <= 1'b1;
            rsp_valid       <= 1'b0;
            rsp_word        <= '0;
        end else begin
            rsp_valid <= 1'b0;
            bus_cnt   <= bus_cnt + 6'd1;
            case (bus_st)
                BS_IDLE: begin
                    bus_cnt   <= '0;
                    req_ready <= running && is_par && !(req_valid && req_ready);
                    if (req_valid && req_ready) begin
                        cur             <= req;
                        chip_select_n   <= 1'b0;
                        cmd_data_select <= req.is_data;
                        bus_st          <= BS_SETUP;
                    end
                end
                BS_SETUP: begin
                    if (bus_cnt == 6'(CS_CYC - 1)) begin
                        bus_cnt        <= '0;
                        write_strobe_n <= cur.read;
                        read_strobe_n  <= !cur.read;
                        bus_st         <= BS_STROBE;
                    end
                end
                BS_STROBE: begin
                    if (bus_cnt == (cur.read ? 6'(RDL_CYC - 1) : 6'(WRL_CYC - 1))) begin
                        bus_cnt        <= '0;
                        write_strobe_n <= 1'b1;
                        read_strobe_n  <= 1'b1;
                        bus_st         <= BS_RECOVER;
                        if (cur.read) begin
                            rsp_valid <= 1'b1;
                            rsp_word  <= lane_unmap(mode, layout, lanes_sync);
                        end
                    end
                end
                BS_RECOVER: begin
                    if (bus_cnt == (cur.read ? 6'(RDH_CYC - 1) : 6'(WRH_CYC - 1))) begin
                        chip_select_n <= 1'b1;
                        bus_st        <= BS_IDLE;
                    end
                end
                default: bus_st <= BS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Lane driver
    // ------------------------------------------------------------
    // Lanes are always driven except across a read, so nothing floats
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            host_lanes_out <= '0;
            host_lanes_oe  <= 1'b1;
        end else if (is_rgb) begin
            host_lanes_oe <= 1'b1;
            if (dot_fall) begin
                host_lanes_out <= rgb_word;
            end
        end else if (bus_st == BS_IDLE && req_valid && req_ready) begin
            host_lanes_out <= req.read ? 18'h0_0000 : lane_map(mode, layout, req.word);
            host_lanes_oe  <= !req.read;
        end else if (bus_st == BS_IDLE) begin
            host_lanes_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // RGB timing
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn || !(running && is_rgb)) begin
            div_cnt     <= '0;
            pixel_clock <= 1'b0;
        end else if (div_cnt == 4'(DOT_HALF - 1)) begin
            div_cnt     <= '0;
            pixel_clock <= !pixel_clock;
        end else begin
            div_cnt <= div_cnt + 4'd1;
        end
    end

    always_comb begin
        next_h = h_cnt + 11'd1;
        next_v = v_cnt;
        if (h_cnt == h_last) begin
            next_h = '0;
            next_v = (v_cnt == V_LAST) ? 11'd0 : v_cnt + 11'd1;
        end
        next_act = (next_h >= H_A0) && (next_h < H_A0 + act_clks)
                && (next_v >= V_A0) && (next_v < V_A0 + 11'(V_ACT));
    end

    always_comb begin
        rgb_word = '0;
        if (ph == 2'd1) begin
            rgb_word = held_ok ? {12'h000, held.green} : 18'h0_0000;
        end else if (ph == 2'd2) begin
            rgb_word = held_ok ? {12'h000, held.blue} : 18'h0_0000;
        end else if (take) begin
            rgb_word = (mode == MODE_RGB6) ? {12'h000, pix.red} : lane_map(mode, layout, pix);
        end
        if (!next_act) begin
            rgb_word = '0;
        end
    end

    // Outputs change on the pixel clock fall, half a period before the
    // display samples, which covers setup and hold with margin
    always_ff @(posedge mclk) begin
        if (!rstn || !(running && is_rgb)) begin
            h_cnt        <= h_last;
            v_cnt        <= V_LAST;
            ph           <= '0;
            held         <= '0;
            held_ok      <= 1'b0;
            pix_ready    <= 1'b0;
            frame_sync_n <= 1'b1;
            line_sync_n  <= 1'b1;
            data_enable  <= 1'b0;
        end else begin
            pix_ready <= dot_pre && next_act && (ph == 2'd0);
            if (dot_fall) begin
                h_cnt        <= next_h;
                v_cnt        <= next_v;
                frame_sync_n <= !(next_v < 11'(V_SYNC));
                line_sync_n  <= !(next_h < 11'(H_SYNC));
                data_enable  <= next_act && ((ph == 2'd0) ? take : held_ok);
                if (ph == 2'd0) begin
                    held    <= pix;
                    held_ok <= take;
                end
                if (next_act && mode == MODE_RGB6) begin
                    ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
                end else begin
                    ph <= '0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_pulse_low: assert property (@(posedge mclk)
        $fell(rstn) |=> !module_reset_n [*8])
        else $error("display reset not held low");
    a_strobe_needs_cs: assert property (@(posedge mclk) disable iff (!rstn)
        (!write_strobe_n || !read_strobe_n) |-> !chip_select_n)
        else $error("strobe without chip select");
    a_write_edge_data: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(write_strobe_n) |-> host_lanes_oe && $stable(host_lanes_out)
                                  && $stable(cmd_data_select))
        else $error("write data moved at strobe rise");
    a_read_bus_free: assert property (@(posedge mclk) disable iff (!rstn)
        !read_strobe_n |-> !host_lanes_oe)
        else $error("host drives lanes during read");
    a_cmd_data_level: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(write_strobe_n) |-> cmd_data_select == cur.is_data)
        else $error("command/data select wrong");
    a_unused_lanes_low: assert property (@(posedge mclk) disable iff (!rstn)
        host_lanes_oe |-> (host_lanes_out & ~lane_map(mode, layout, 18'h3_FFFF)) == 18'h0_0000)
        else $error("unused lane driven high");
    a_de_in_active: assert property (@(posedge mclk) disable iff (!rstn)
        data_enable |-> is_rgb && line_sync_n && frame_sync_n)
        else $error("data enable outside active area");
    a_frame_on_line: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(frame_sync_n) |-> !line_sync_n)
        else $error("frame sync not on line start");
    a_dot_period: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(pixel_clock) && running && is_rgb |-> ##DOT_PER $rose(pixel_clock))
        else $error("pixel clock period wrong");
    a_strap_steady: assert property (@(posedge mclk) disable iff (!rstn)
        module_reset_n && $past(module_reset_n)
            |-> $stable({iface_strap_3, iface_strap_2, iface_strap_1, iface_strap_0}))
        else $error("straps changed after reset");

    c_write_cmd: cover property (@(posedge mclk) disable iff (!rstn)
        $rose(write_strobe_n) && !cmd_data_select);
    c_read_done: cover property (@(posedge mclk) disable iff (!rstn) rsp_valid);
    c_pixel_out: cover property (@(posedge mclk) disable iff (!rstn) $rose(data_enable));
    c_frame_start: cover property (@(posedge mclk) disable iff (!rstn) $fell(frame_sync_n));
endmodule

// ### dv/dhl_disp.sv
// Purpose: behavioural display module facing dhl_host
// Assumes: straps are {layout, mode}; codes below 4 are parallel
// Notes:   released lanes show the inverse of the last wire value
`timescale 1ns/1ps
module dhl_disp (
    // Clock and display pins
    input  wire logic        mclk,
    input  wire logic        module_reset_n,
    input  wire logic [3:0]  straps,
    input  wire logic        chip_select_n,
    input  wire logic        cmd_data_select,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        frame_sync_n,
    input  wire logic        line_sync_n,
    input  wire logic        pixel_clock,
    input  wire logic        data_enable,
    input  wire logic [17:0] host_lanes_out,
    input  wire logic        host_lanes_oe,
    // Read answer and resolved wire
    input  wire logic [17:0] rd_word,
    output logic [17:0]      host_lanes_in
);
    logic [17:0] last;
    logic [17:0] wr_lanes;
    logic        wr_dc;
    logic [17:0] pix [0:2];
    int          n_pix;
    logic        vs_seen;
    logic        hs_seen;
    logic        drv;
    // Never drives in RGB or serial modes
    assign drv = module_reset_n && !chip_select_n && !read_strobe_n
                 && straps[2:0] < 3'h4;
    // Fight on the wire shows up as unknown
    assign host_lanes_in = host_lanes_oe ? (drv ? {18{1'bx}} : host_lanes_out)
                         : (drv ? rd_word : ~last);
    always_ff @(posedge mclk) begin
        last <= host_lanes_in;
    end
    always @(posedge write_strobe_n) begin
        if (module_reset_n && !chip_select_n) begin
            wr_lanes <= host_lanes_out;
            wr_dc    <= cmd_data_select;
        end
    end
    always @(posedge pixel_clock or negedge module_reset_n) begin
        if (!module_reset_n) begin
            n_pix   <= 0;
            vs_seen <= 1'b0;
            hs_seen <= 1'b0;
        end else begin
            vs_seen <= vs_seen | !frame_sync_n;
            hs_seen <= hs_seen | !line_sync_n;
            if (data_enable && n_pix < 3) begin
                pix[n_pix] <= host_lanes_out;
                n_pix      <= n_pix + 1;
            end
        end
    end
endmodule

// ### dv/tb.sv
// Purpose: self-checking bench for dhl_host against a display model
// Assumes: mode straps are taken while rstn is low
// Notes:   short reset-complete wait and a tiny frame keep runs quick
`timescale 1ns/1ps
module tb;
    import dhl_pkg::*;
    logic        mclk, rstn, req_valid, pix_valid;
    dhl_mode_t   cfg_mode;
    dhl_layout_t cfg_layout;
    dhl_req_t    req;
    dhl_pix_t    pix;
    logic [17:0] rd_word, rsp_word, host_lanes_out, host_lanes_in, got;
    logic        link_ready, req_ready, rsp_valid, pix_ready, module_reset_n;
    logic        iface_strap_0, iface_strap_1, iface_strap_2, iface_strap_3;
    logic        chip_select_n, cmd_data_select, write_strobe_n, read_strobe_n;
    logic        frame_sync_n, line_sync_n, pixel_clock, data_enable, host_lanes_oe;
    int          n_mismatch, num_checks;
    dhl_host #(.REST_CYCLES(20), .H_ACT(4), .V_ACT(3)) dhl_host_i (
        .mclk, .rstn, .cfg_mode, .cfg_layout, .link_ready, .req_valid, .req,
        .req_ready, .rsp_valid, .rsp_word, .pix_valid, .pix, .pix_ready,
        .module_reset_n, .iface_strap_0, .iface_strap_1, .iface_strap_2,
        .iface_strap_3, .chip_select_n, .cmd_data_select, .write_strobe_n,
        .read_strobe_n, .frame_sync_n, .line_sync_n, .pixel_clock,
        .data_enable, .host_lanes_out, .host_lanes_oe, .host_lanes_in);
    dhl_disp dhl_disp_i (
        .mclk, .module_reset_n, .chip_select_n, .cmd_data_select,
        .straps({iface_strap_3, iface_strap_2, iface_strap_1, iface_strap_0}),
        .write_strobe_n, .read_strobe_n, .frame_sync_n, .line_sync_n,
        .pixel_clock, .data_enable, .host_lanes_out, .host_lanes_oe,
        .rd_word, .host_lanes_in);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(string nm, logic [17:0] seen, logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rst(dhl_mode_t m, dhl_layout_t l, logic [3:0] code);
        int i;
        tick();
        rstn = 1'b0;
        cfg_mode = m;
        cfg_layout = l;
        repeat (2) tick();
        rstn = 1'b1;
        tick();
        chk("reset low", 18'(module_reset_n), 18'h0_0000);
        for (i = 0; i < 3000 && link_ready !== 1'b1; i++) tick();
        chk("link ready", 18'(link_ready), 18'h0_0001);
        chk("reset high", 18'(module_reset_n), 18'h0_0001);
        chk("straps", 18'({iface_strap_3, iface_strap_2, iface_strap_1,
                           iface_strap_0}), 18'(code));
    endtask
    // One transfer; keeps the read answer in got
    task automatic xfer(logic rd, logic dc, logic [17:0] w);
        int i;
        req = {rd, dc, w};
        req_valid = 1'b1;
        for (i = 0; i < 200 && req_ready !== 1'b1; i++) tick();
        // Ready seen settled, so the next edge takes the request
        tick();
        req_valid = 1'b0;
        for (i = 0; i < 200 && req_ready !== 1'b1; i++) begin
            if (rsp_valid === 1'b1) got = rsp_word;
            tick();
        end
        chk("idle", 18'(req_ready), 18'h0_0001);
    endtask
    task automatic t_par(dhl_mode_t m, dhl_layout_t l, logic [3:0] code,
                         logic [17:0] w, wexp, rl, rexp);
        rst(m, l, code);
        xfer(1'b0, 1'b0, w);
        chk("write lanes", dhl_disp_i.wr_lanes, wexp);
        chk("cmd select", 18'(dhl_disp_i.wr_dc), 18'h0_0000);
        xfer(1'b0, 1'b1, w);
        chk("data select", 18'(dhl_disp_i.wr_dc), 18'h0_0001);
        rd_word = rl;
        got = 18'h0_0000;
        xfer(1'b1, 1'b1, 18'h0_0000);
        chk("read word", got, rexp);
    endtask
    task automatic t_rgb(dhl_mode_t m, logic [3:0] code,
                         logic [17:0] e0, e1, e2);
        int i;
        rst(m, PARALLEL_LAYOUT_LOW, code);
        pix = {6'h2B, 6'h15, 6'h33};
        pix_valid = 1'b1;
        for (i = 0; i < 20000 && dhl_disp_i.n_pix < 3; i++) tick();
        pix_valid = 1'b0;
        chk("refused", 18'(req_ready), 18'h0_0000);
        chk("lanes driven", 18'(host_lanes_oe), 18'h0_0001);
        chk("pixel 0", dhl_disp_i.pix[0], e0);
        chk("pixel 1", dhl_disp_i.pix[1], e1);
        chk("pixel 2", dhl_disp_i.pix[2], e2);
        chk("frame sync", 18'(dhl_disp_i.vs_seen), 18'h0_0001);
        chk("line sync", 18'(dhl_disp_i.hs_seen), 18'h0_0001);
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        results();
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        pix_valid = 1'b0;
        req = '0;
        pix = '0;
        rd_word = 18'h0_0000;
        cfg_mode = MODE_PAR8;
        cfg_layout = PARALLEL_LAYOUT_LOW;
        t_par(MODE_PAR8, PARALLEL_LAYOUT_LOW, 4'h0, 18'h3_FFA5, 18'h0_00A5,
              18'h3_FF5A, 18'h0_005A);
        t_par(MODE_PAR8, PARALLEL_LAYOUT_HIGH, 4'h8, 18'h3_FFC3, 18'h3_0C00,
              18'h2_95FF, 18'h0_00A5);
        t_par(MODE_PAR9, PARALLEL_LAYOUT_LOW, 4'h1, 18'h3_FF5A, 18'h0_015A,
              18'h3_FE5A, 18'h0_005A);
        t_par(MODE_PAR9, PARALLEL_LAYOUT_HIGH, 4'h9, 18'h3_FF5A, 18'h2_B400,
              18'h2_B5A5, 18'h0_015A);
        t_par(MODE_PAR16, PARALLEL_LAYOUT_LOW, 4'h2, 18'h3_A5C3, 18'h2_9586,
              18'h2_9787, 18'h0_A5C3);
        t_par(MODE_PAR16, PARALLEL_LAYOUT_HIGH, 4'hA, 18'h3_A5C3, 18'h2_9586,
              18'h2_9787, 18'h0_A5C3);
        t_par(MODE_PAR18, PARALLEL_LAYOUT_LOW, 4'h3, 18'h2_AAAA, 18'h2_AAAA,
              18'h1_5555, 18'h1_5555);
        t_rgb(MODE_RGB6, 4'h4, 18'h0_002B, 18'h0_0015, 18'h0_0033);
        t_rgb(MODE_RGB16, 4'h5, 18'h2_A572, 18'h2_A572, 18'h2_A572);
        t_rgb(MODE_RGB18, 4'h6, 18'h2_B573, 18'h2_B573, 18'h2_B573);
        rst(MODE_SPI4, PARALLEL_LAYOUT_LOW, 4'h7);
        repeat (5) tick();
        chk("serial refused", 18'(req_ready), 18'h0_0000);
        results();
    end
endmodule
